// ==== rtl/rtc_set_and_soft_reset.sv ====
// Clock holding-register front end with keyed software reset
`timescale 1ns/1ps
`default_nettype none
module rtc_set_and_soft_reset
    import rtc_pkg::*;
#(
    parameter int TICK = TICK_CYCLES
) (
    input  wire logic        clk_in,
    input  wire logic        nrst_in,
    input  wire reg_req_s    req_in,
    output logic [15:0]      rdata_out,
    output logic             rvalid_out,
    output logic             soft_reset_out,
    output var  time_s       time_out
);
    typedef struct packed {
        time_s       now;
        time_s       pend;
        logic [16:0] tick;
        logic [15:0] key;
        logic        key_armed;
        logic [15:0] rdata;
        logic        rvalid;
        logic        srst;
    } state_s;

    state_s st;
    state_s next_st;

    logic [7:0]  nxt_sec, nxt_min, nxt_hour, nxt_day, nxt_month, nxt_year;
    logic [15:0] nxt_ms;
    logic        c_ms, c_sec, c_min, c_hour, c_day, c_month;
    logic        tick_hit;

    assign tick_hit = (st.tick == 17'(TICK - 1));

    // Field chain, milliseconds up to year
    rtc_wrap_counter #(.W(16)) u_ms (.value_in(st.now.millis), .low_in(16'h0000),
        .high_in(MILLIS_MAX), .step_in(tick_hit), .next_out(nxt_ms), .carry_out(c_ms));
    rtc_wrap_counter #(.W(8)) u_sec (.value_in(st.now.sec), .low_in(RESET_ZERO),
        .high_in(MINSEC_MAX), .step_in(c_ms), .next_out(nxt_sec), .carry_out(c_sec));
    rtc_wrap_counter #(.W(8)) u_min (.value_in(st.now.min), .low_in(RESET_ZERO),
        .high_in(MINSEC_MAX), .step_in(c_sec), .next_out(nxt_min), .carry_out(c_min));
    // Hour wraps 23 to 0, so 24 is coded 0
    rtc_wrap_counter #(.W(8)) u_hour (.value_in(st.now.hour), .low_in(RESET_ZERO),
        .high_in(HOUR_MAX), .step_in(c_min), .next_out(nxt_hour), .carry_out(c_hour));
    rtc_wrap_counter #(.W(8)) u_day (.value_in(st.now.day), .low_in(RESET_DAY),
        .high_in(DAY_MAX), .step_in(c_hour), .next_out(nxt_day), .carry_out(c_day));
    // Month 1..12 binary
    rtc_wrap_counter #(.W(8)) u_month (.value_in(st.now.month), .low_in(RESET_MONTH),
        .high_in(MONTH_MAX), .step_in(c_day), .next_out(nxt_month), .carry_out(c_month));
    rtc_wrap_counter #(.W(8)) u_year (.value_in(st.now.year), .low_in(RESET_YEAR),
        .high_in(YEAR_MAX), .step_in(c_month), .next_out(nxt_year), .carry_out());

    always_comb begin
        next_st        = st;
        next_st.rvalid = 1'b0;
        next_st.srst   = 1'b0;
        next_st.tick   = tick_hit ? 17'h00000 : st.tick + 17'h00001;
        // Key generator, steps every cycle but holds while a key is being read or is armed
        next_st.key    = {1'b0, st.key[15:1]} ^ (st.key[0] ? KEY_POLY : 16'h0000);
        next_st.now    = '{month: nxt_month, year: nxt_year, hour: nxt_hour, day: nxt_day,
                           sec: nxt_sec, min: nxt_min, millis: nxt_ms};
        if (req_in.wr) begin
            if (req_in.addr == REG_MONTH_YEAR) begin
                next_st.pend.month = req_in.wdata[HI_LSB +: 8];
                next_st.pend.year  = req_in.wdata[LO_LSB +: 8];
            end else if (req_in.addr == REG_HOUR_DAY) begin
                next_st.pend.hour = req_in.wdata[HI_LSB +: 8];
                next_st.pend.day  = req_in.wdata[LO_LSB +: 8];
            end else if (req_in.addr == REG_SEC_MIN) begin
                next_st.pend.sec = req_in.wdata[HI_LSB +: 8];
                next_st.pend.min = req_in.wdata[LO_LSB +: 8];
            end else if (req_in.addr == REG_MILLIS_COMMIT) begin
                // Commit all pending fields at once
                next_st.now        = st.pend;
                next_st.now.millis = req_in.wdata;
                next_st.pend.millis = req_in.wdata;
                next_st.tick       = 17'h00000;
            end else if (req_in.addr == REG_SOFT_RESET) begin
                // Exact match against the key last read
                next_st.srst      = st.key_armed && (req_in.wdata == st.key);
                next_st.key_armed = 1'b0;
            end
        end else if (req_in.rd) begin
            next_st.rvalid = 1'b1;
            next_st.rdata  = 16'h0000;
            if (req_in.addr == REG_MONTH_YEAR) begin
                next_st.rdata = {st.now.month, st.now.year};
            end else if (req_in.addr == REG_HOUR_DAY) begin
                next_st.rdata = {st.now.hour, st.now.day};
            end else if (req_in.addr == REG_SEC_MIN) begin
                next_st.rdata = {st.now.sec, st.now.min};
            end else if (req_in.addr == REG_MILLIS_COMMIT) begin
                next_st.rdata = st.now.millis;
            end else if (req_in.addr == REG_SOFT_RESET) begin
                // Hand out the key and hold it for the write-back
                next_st.rdata     = st.key;
                next_st.key       = st.key;
                next_st.key_armed = 1'b1;
            end
        end
        if (st.key_armed && !(req_in.rd && req_in.addr == REG_SOFT_RESET)) begin
            next_st.key = st.key;
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            st           <= '0;
            st.now.month <= RESET_MONTH;
            st.now.year  <= RESET_YEAR;
            st.now.day   <= RESET_DAY;
            st.pend.month <= RESET_MONTH;
            st.pend.year <= RESET_YEAR;
            st.pend.day  <= RESET_DAY;
            st.key       <= KEY_SEED;
        end else begin
            st <= next_st;
        end
    end

    assign rdata_out      = st.rdata;
    assign rvalid_out     = st.rvalid;
    assign soft_reset_out = st.srst;
    assign time_out       = st.now;

    a_commit_loads: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (req_in.wr && req_in.addr == REG_MILLIS_COMMIT) |=>
        (st.now.month == $past(st.pend.month) && st.now.sec == $past(st.pend.sec)))
        else $error("commit did not load pending time");

    a_pending_held: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (req_in.wr && req_in.addr == REG_SEC_MIN) |=> (st.pend.sec == $past(req_in.wdata[15:8])
        && st.pend.min == $past(req_in.wdata[7:0]) && st.now.sec == $past(nxt_sec)))
        else $error("sec/min write not held pending");

    a_read_layout: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (req_in.rd && !req_in.wr && req_in.addr == REG_HOUR_DAY) |=>
        (rvalid_out && rdata_out == {$past(st.now.hour), $past(st.now.day)}))
        else $error("hour/day read wrong");

    sequence key_read_s;
        req_in.rd && !req_in.wr && req_in.addr == REG_SOFT_RESET;
    endsequence

    a_key_reset: assert property (@(posedge clk_in) disable iff (!nrst_in)
        key_read_s ##1 !(req_in.wr && req_in.addr == REG_SOFT_RESET)
        ##1 (req_in.wr && req_in.addr == REG_SOFT_RESET && req_in.wdata == rdata_out)
        |=> soft_reset_out)
        else $error("matching key did not reset");

    a_bad_key: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (req_in.wr && req_in.addr == REG_SOFT_RESET && req_in.wdata != st.key) |=> !soft_reset_out)
        else $error("wrong key caused reset");

    a_hour_wrap: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (st.now.hour == HOUR_MAX && c_min && !req_in.wr) |=> st.now.hour == 8'h00)
        else $error("hour did not wrap to zero");

    a_month_range: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (st.now.month == MONTH_MAX && c_day && !req_in.wr) |=> st.now.month == RESET_MONTH)
        else $error("month left range");

    a_sec_tick: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (c_ms && !req_in.wr && st.now.sec < MINSEC_MAX) |=> st.now.sec == $past(st.now.sec) + 8'h01)
        else $error("second did not advance");

    sequence commit_wr_s;
        req_in.wr && req_in.addr == REG_MILLIS_COMMIT;
    endsequence

    a_commit_restart: assert property (@(posedge clk_in) disable iff (!nrst_in)
        commit_wr_s |=> (st.tick == 17'h00000 && st.now.millis == $past(req_in.wdata)))
        else $error("commit did not restart millis");

    a_pending_month: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (req_in.wr && req_in.addr == REG_MONTH_YEAR) |=>
        (st.pend.month == $past(req_in.wdata[15:8]) && st.pend.year == $past(req_in.wdata[7:0])
        && st.now.month == $past(nxt_month)))
        else $error("month/year write not held pending");

    a_pending_hour: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (req_in.wr && req_in.addr == REG_HOUR_DAY) |=>
        (st.pend.hour == $past(req_in.wdata[15:8]) && st.pend.day == $past(req_in.wdata[7:0])
        && st.now.hour == $past(nxt_hour)))
        else $error("hour/day write not held pending");

    a_sec_read: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (req_in.rd && !req_in.wr && req_in.addr == REG_SEC_MIN) |=>
        (rvalid_out && rdata_out == {$past(st.now.sec), $past(st.now.min)}))
        else $error("sec/min read wrong");

    a_millis_read: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (req_in.rd && !req_in.wr && req_in.addr == REG_MILLIS_COMMIT) |=>
        (rvalid_out && rdata_out == $past(st.now.millis)))
        else $error("millis read wrong");

    a_unmapped_read: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (req_in.rd && !req_in.wr && req_in.addr != REG_MONTH_YEAR
        && req_in.addr != REG_HOUR_DAY && req_in.addr != REG_SEC_MIN
        && req_in.addr != REG_MILLIS_COMMIT && req_in.addr != REG_SOFT_RESET) |=>
        (rvalid_out && rdata_out == 16'h0000))
        else $error("unmapped read not zero");

    a_rvalid_pulse: assert property (@(posedge clk_in) disable iff (!nrst_in)
        !(req_in.rd && !req_in.wr) |=> !rvalid_out)
        else $error("read valid without read");

    a_key_handout: assert property (@(posedge clk_in) disable iff (!nrst_in)
        key_read_s |=> (rvalid_out && rdata_out == $past(st.key) && st.key_armed))
        else $error("key read wrong");

    a_key_frozen: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (st.key_armed && !(req_in.wr && req_in.addr == REG_SOFT_RESET)) |=>
        st.key == $past(st.key))
        else $error("armed key changed");

    a_disarmed_key: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (req_in.wr && req_in.addr == REG_SOFT_RESET && !st.key_armed) |=> !soft_reset_out)
        else $error("reset without key read");

    a_reset_source: assert property (@(posedge clk_in) disable iff (!nrst_in)
        !(req_in.wr && req_in.addr == REG_SOFT_RESET) |=> !soft_reset_out)
        else $error("reset without key write");

    a_day_wrap: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (st.now.day == DAY_MAX && c_hour && !req_in.wr) |=> st.now.day == RESET_DAY)
        else $error("day did not wrap");
endmodule
`default_nettype wire

// ==== rtl/rtc_pkg.sv ====
// Package: register map, field layout, timing and carrier types for the clock front end
package rtc_pkg;
    localparam logic [7:0]  REG_MONTH_YEAR    = 8'haf;
    localparam logic [7:0]  REG_HOUR_DAY      = 8'hb0;
    localparam logic [7:0]  REG_SEC_MIN       = 8'hb1;
    localparam logic [7:0]  REG_MILLIS_COMMIT = 8'hb2;
    localparam logic [7:0]  REG_SOFT_RESET    = 8'hc5;
    localparam int          HI_LSB            = 8;
    localparam int          LO_LSB            = 0;
    localparam int          CLK_HZ            = 125000000;
    localparam int          MS_PER_S          = 1000;
    localparam int          TICK_CYCLES       = CLK_HZ / MS_PER_S;
    localparam logic [7:0]  RESET_MONTH       = 8'h01;
    localparam logic [7:0]  RESET_YEAR        = 8'h16;
    localparam logic [7:0]  RESET_DAY         = 8'h01;
    localparam logic [7:0]  RESET_ZERO        = 8'h00;
    localparam logic [15:0] KEY_SEED          = 16'ha5c3;
    localparam logic [15:0] KEY_POLY          = 16'hb400;
    localparam logic [7:0]  MONTH_MAX         = 8'h0c;
    localparam logic [7:0]  YEAR_MAX          = 8'h32;
    localparam logic [7:0]  HOUR_MAX          = 8'h17;
    localparam logic [7:0]  DAY_MAX           = 8'h1f;
    localparam logic [7:0]  MINSEC_MAX        = 8'h3b;
    localparam logic [15:0] MILLIS_MAX        = 16'h03e7;

    typedef struct packed {
        logic [7:0]  month;
        logic [7:0]  year;
        logic [7:0]  hour;
        logic [7:0]  day;
        logic [7:0]  sec;
        logic [7:0]  min;
        logic [15:0] millis;
    } time_s;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [15:0] wdata;
    } reg_req_s;
endpackage

// ==== rtl/rtc_wrap_counter.sv ====
// Wrapping field counter used for each clock field
`timescale 1ns/1ps
`default_nettype none
module rtc_wrap_counter #(
    parameter int W = 8
) (
    input  wire logic [W-1:0] value_in,
    input  wire logic [W-1:0] low_in,
    input  wire logic [W-1:0] high_in,
    input  wire logic         step_in,
    output logic [W-1:0]      next_out,
    output logic              carry_out
);
    always_comb begin
        next_out  = value_in;
        carry_out = 1'b0;
        if (step_in) begin
            if (value_in >= high_in) begin
                next_out  = low_in;
                carry_out = 1'b1;
            end else begin
                next_out = value_in + {{(W-1){1'b0}}, 1'b1};
            end
        end
    end
endmodule
`default_nettype wire

// ==== verif/host_model.sv ====
// Bus master model that sets the clock and requests keyed resets
`timescale 1ns/1ps
`default_nettype none
module host_model
    import rtc_pkg::*;
#(
    parameter int HOLDOFF = 16
) (
    input  wire logic     clk_in,
    output var  reg_req_s req_out
);
    initial req_out = '0;

    // One access; on release wr and rd drop to 0 and addr and wdata go to inverted values
    task automatic access(input logic wr, input logic [7:0] a, input logic [15:0] d);
        @(negedge clk_in);
        req_out = '{wr: wr, rd: !wr, addr: a, wdata: d};
        @(negedge clk_in);
        req_out = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask

    // Loads the full date and time
    task automatic set_time(input logic [47:0] t);
        access(1'b1, REG_MONTH_YEAR, t[47:32]);
        access(1'b1, REG_HOUR_DAY, t[31:16]);
        access(1'b1, REG_SEC_MIN, t[15:0]);
        access(1'b1, REG_MILLIS_COMMIT, 16'h0000);
    endtask

    // Quiet period after a reset
    task automatic holdoff();
        repeat (HOLDOFF) @(negedge clk_in);
    endtask
endmodule
`default_nettype wire

// ==== verif/testbench.sv ====
// Self-checking testbench for the clock front end
`timescale 1ns/1ps
`default_nettype none
module testbench
    import rtc_pkg::*;
();
    logic        clk_in    = 1'b0;
    logic        nrst_in   = 1'b0;
    reg_req_s    req;
    logic [15:0] rdata;
    logic        rvalid;
    logic        sreset;
    time_s       now;
    logic [15:0] key;
    int          bad_count = 0;
    int          tests_run = 0;
    int          cycles    = 0;

    always #4 clk_in = ~clk_in;

    host_model host_u (
        .clk_in  (clk_in),
        .req_out (req)
    );

    rtc_set_and_soft_reset #(.TICK(4)) dut_u (
        .clk_in         (clk_in),
        .nrst_in        (nrst_in),
        .req_in         (req),
        .rdata_out      (rdata),
        .rvalid_out     (rvalid),
        .soft_reset_out (sreset),
        .time_out       (now)
    );

    task automatic check(input logic [47:0] g, input logic [47:0] e);
        tests_run++;
        if (g !== e) begin
            bad_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Reset values, pending fields, commit and read-back
    task automatic t_set_commit();
        logic [15:0] exp_w [4];
        // Millis read lands one tick after the commit
        exp_w = '{16'h0c32, 16'h0a1f, 16'h1005, 16'h0001};
        check(now[63:16], {RESET_MONTH, RESET_YEAR, RESET_ZERO, RESET_DAY, RESET_ZERO, RESET_ZERO});
        check({30'h0, rvalid, sreset, rdata}, 48'h0);
        host_u.access(1'b1, REG_MONTH_YEAR, 16'h0c32);
        host_u.access(1'b1, REG_HOUR_DAY, 16'h0a1f);
        host_u.access(1'b1, REG_SEC_MIN, 16'h1005);
        check({40'h0, now.month}, {40'h0, RESET_MONTH});
        host_u.access(1'b1, REG_MILLIS_COMMIT, 16'h0000);
        check(now[63:16], 48'h0c320a1f1005);
        check({32'h0, now.millis}, 48'h0);
        for (int i = 0; i < 4; i++) begin
            host_u.access(1'b0, REG_MONTH_YEAR + 8'(i), 16'h0000);
            check({31'h0, rvalid, rdata}, {31'h0, 1'b1, exp_w[i]});
        end
        host_u.access(1'b0, 8'h00, 16'h0000);
        check({31'h0, rvalid, rdata}, {31'h0, 1'b1, 16'h0000});
        host_u.access(1'b1, 8'h00, 16'hffff);
        check(now[63:16], 48'h0c320a1f1005);
        $display("test set_commit done");
    endtask

    // Every field wraps at its top value
    task automatic t_rollover();
        host_u.set_time(48'h0c32171f3b3b);
        repeat (4100) @(negedge clk_in);
        check(now[63:16], {8'h01, RESET_YEAR, 8'h00, 8'h01, 8'h00, 8'h00});
        check({32'h0, now.millis}, 48'h19);
        $display("test rollover done");
    endtask

    // Keyed reset: wrong key, disarmed key, then a match
    task automatic t_soft_reset();
        host_u.access(1'b0, REG_SOFT_RESET, 16'h0000);
        key = rdata;
        check({47'h0, rvalid}, 48'h1);
        host_u.access(1'b1, REG_SOFT_RESET, key ^ 16'h0001);
        check({47'h0, sreset}, 48'h0);
        host_u.access(1'b1, REG_SOFT_RESET, key);
        check({47'h0, sreset}, 48'h0);
        host_u.access(1'b0, REG_SOFT_RESET, 16'h0000);
        key = rdata;
        host_u.access(1'b0, REG_SEC_MIN, 16'h0000);
        host_u.access(1'b1, REG_SOFT_RESET, key);
        check({47'h0, sreset}, 48'h1);
        @(negedge clk_in);
        check({47'h0, sreset}, 48'h0);
        host_u.holdoff();
        host_u.access(1'b0, REG_SOFT_RESET, 16'h0000);
        key = rdata;
        host_u.access(1'b1, REG_SOFT_RESET, key);
        check({47'h0, sreset}, 48'h1);
        host_u.holdoff();
        $display("test soft_reset done");
    endtask

    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 10000) begin
            bad_count++;
            summarize();
        end
    end

    initial begin
        repeat (4) @(negedge clk_in);
        nrst_in = 1'b1;
        t_set_commit();
        t_soft_reset();
        t_rollover();
        summarize();
    end
endmodule
`default_nettype wire
